// ### core/pml_consts.svh
`ifndef PML_CONSTS_SVH
`define PML_CONSTS_SVH
// cpu-side register offsets
`define PML_OFS_SLOT_ONE 8'h30
`define PML_OFS_SLOT_TWO 8'h34
`define PML_OFS_LOCK_CTL 8'h60
`define PML_OFS_ENABLES 8'h74
// pci_side_enables field positions
`define PML_EN_ARB 0
`define PML_EN_ADDON 1
`define PML_EN_CFG_DONE 2
`define PML_EN_SET_INT 3
`define PML_EN_RST_NMI 4
// bus_lock_control field positions
`define PML_LK_REQ 0
`define PML_LK_UNLOCK 1
`define PML_LK_RLIM 2
`define PML_LK_ABORT 3
// reset values and slot count
`define PML_EN_RST 5'h00
`define PML_SLOT_RST 32'h0000_0000
`define PML_SLOT_COUNT 2
`endif

// ### core/pml_if.sv
`timescale 1ns/100ps
interface pml_if;
   logic lock_request; // software asks for exclusive access
   logic unlock_dis; // target locking disabled
   logic mst_start; // our master access starts
   logic mst_done; // our master access completed
   logic mst_retry; // our master access was retried
   logic mst_abort; // master or target abort seen
   logic retry_limit; // retry counter reached its limit
   logic bus_lock_free; // bus conditions allow taking the lock
   logic tgt_start; // a target cycle addresses us
   logic frame_n; // pci frame, active low
   logic lock_n; // pci lock as seen on the wire
   logic lock_n_drv; // lock level we drive
   logic lock_oe; // we drive lock
   logic tgt_locked; // we are a locked target
   logic excl_only; // only the locked target may be used
   logic redo; // retry the locked transfer
   logic abort_set; // pulse: abort during lock
   logic rlim_set; // pulse: retry limit during lock

   modport top
   (
      output lock_request, unlock_dis, mst_start, mst_done, mst_retry, mst_abort,
      output retry_limit, bus_lock_free, tgt_start, frame_n, lock_n,
      input lock_n_drv, lock_oe, tgt_locked, excl_only, redo, abort_set, rlim_set
   );
   modport lock
   (
      input lock_request, unlock_dis, mst_start, mst_done, mst_retry, mst_abort,
      input retry_limit, bus_lock_free, tgt_start, frame_n, lock_n,
      output lock_n_drv, lock_oe, tgt_locked, excl_only, redo, abort_set, rlim_set
   );
endinterface : pml_if

// ### core/pml_lock_ctl.sv
`timescale 1ns/100ps
module pml_lock_ctl
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_sys_rst, // synchronous reset, high
   input wire logic i_clk_en, // freezes state while low
   pml_if.lock lk // link to the control block
);
   pml_pkg::pml_lock_state_type st_reg; // registered state
   pml_pkg::pml_lock_state_type st_next; // next state

   // lock engine: master ownership and locked target
   always_comb
   begin
      st_next = st_reg;
      st_next.abort_set = 1'b0;
      st_next.redo = 1'b0;
      st_next.rlim_set = 1'b0;
      case (st_reg.st)
         pml_pkg::PML_LK_IDLE:
         begin
            // master side has priority over being locked as target
            if (lk.lock_request && lk.mst_start && lk.bus_lock_free)
            begin
               st_next.st = pml_pkg::PML_LK_OWN;
            end
            else if (!lk.unlock_dis && lk.tgt_start && !lk.frame_n && !lk.lock_n)
            begin
               st_next.st = pml_pkg::PML_LK_TGT;
            end
         end
         pml_pkg::PML_LK_OWN:
         begin
            st_next.abort_set = lk.mst_abort;
            st_next.rlim_set = lk.retry_limit;
            st_next.redo = lk.mst_retry && !lk.mst_done;
            // release only after the final access completes
            if (lk.mst_done && !lk.lock_request)
            begin
               st_next.st = pml_pkg::PML_LK_IDLE;
            end
         end
         pml_pkg::PML_LK_TGT:
         begin
            // both frame and lock must be high to leave
            if (lk.frame_n && lk.lock_n)
            begin
               st_next.st = pml_pkg::PML_LK_IDLE;
            end
         end
         default:
         begin
            st_next.st = pml_pkg::PML_LK_IDLE;
         end
      endcase
      st_next.lock_oe = (st_next.st == pml_pkg::PML_LK_OWN);
      st_next.lock_n = !st_next.lock_oe;
      st_next.excl_only = st_next.lock_oe;
      st_next.tgt_locked = (st_next.st == pml_pkg::PML_LK_TGT);
   end

   // state register
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st_reg <= '{st: pml_pkg::PML_LK_IDLE, lock_n: 1'b1, default: 1'b0};
      end
      else if (i_clk_en)
      begin
         st_reg <= st_next;
      end
   end

   assign lk.lock_n_drv = st_reg.lock_n;
   assign lk.lock_oe = st_reg.lock_oe;
   assign lk.tgt_locked = st_reg.tgt_locked;
   assign lk.excl_only = st_reg.excl_only;
   assign lk.redo = st_reg.redo;
   assign lk.abort_set = st_reg.abort_set;
   assign lk.rlim_set = st_reg.rlim_set;
endmodule : pml_lock_ctl

// ### core/pml_pkg.sv
package pml_pkg;
   // lock engine states, one-hot
   typedef enum logic [2:0]
   {
      PML_LK_IDLE = 3'b001,
      PML_LK_OWN = 3'b010,
      PML_LK_TGT = 3'b100
   } pml_lock_st_type;

   // full state of the lock engine
   typedef struct packed
   {
      pml_lock_st_type st;
      logic lock_n;
      logic lock_oe;
      logic tgt_locked;
      logic excl_only;
      logic redo;
      logic abort_set;
      logic rlim_set;
   } pml_lock_state_type;

   // full state of the control block
   typedef struct packed
   {
      logic [4:0] en;
      logic [1:0][31:0] slot;
      logic [1:0] mb_flag;
      logic lock_req;
      logic unlock_dis;
      logic rlim_hit;
      logic abort_hit;
      logic inta_n;
      logic nmi_n;
      logic [31:0] cpu_rdata;
      logic cpu_ack;
      logic cpu_retry;
      logic [31:0] pci_rdata;
      logic pci_ack;
      logic pci_retry;
      logic refresh_ok;
   } pml_top_state_type;
endpackage : pml_pkg

// ### core/pml_top.sv
// Behaviour
// - retry pci target cycles until setup complete
// - add-on cpu pulse write raises pci interrupt
// - pulse bit reads back interrupt state
// - pulse bit clears itself one clock later
// - pci write to interrupt bit negates it
// - system error asserts cpu non-maskable interrupt
// - add-on release bit negates nmi, self-clears
// - two shared mailbox words at 0x30, 0x34
// - mailboxes answer memory cycles once space on
// - pci mailbox access sets its flag
// - cpu mailbox access clears its flag
// - lock request makes next access exclusive
// - cleared request releases after final access
// - locked: only locked target, retry until done
// - retry limit during lock sets status bit
// - abort during lock sets status bit
// - target-lock disable bit blocks target locking
// - locked target refuses others until idle
// - refresh keeps running while locked
// - reserved bits read as zero
// - lock control word at offset 0x60
// - enable register clears at reset
`timescale 1ns/100ps
`include "pml_consts.svh"
module pml_top
#(
   parameter int ADDR_W = 8 // cpu register offset width
)
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_sys_rst, // synchronous reset, high
   input wire logic i_clk_en, // freezes all state while low
   input wire logic i_cpu_req, // cpu register access strobe
   input wire logic i_cpu_wr, // 1 write, 0 read
   input wire logic [ADDR_W-1:0] i_cpu_addr, // cpu register offset
   input wire logic [31:0] i_cpu_wdata, // cpu write data
   output logic [31:0] o_cpu_rdata, // cpu read data
   output logic o_cpu_ack, // cpu access done
   output logic o_cpu_retry, // cpu access refused
   input wire logic i_pci_req, // pci target cycle strobe
   input wire logic i_pci_mem, // cycle is a memory cycle
   input wire logic i_mem_space_on, // command register memory enable
   input wire logic [1:0] i_pci_slot_hit, // one-hot mailbox address hit
   input wire logic i_pci_wr, // pci write, else read
   input wire logic [31:0] i_pci_wdata, // pci write data
   input wire logic i_pci_int_wr, // pci write to add-on interrupt bit
   output logic [31:0] o_pci_rdata, // pci read data
   output logic o_pci_ack, // pci mailbox access done
   output logic o_pci_retry, // pci target cycle retried
   output logic [1:0] o_mb_flags, // mailbox interrupt flags
   output logic o_inta_n, // pci interrupt, low active
   input wire logic i_serr_n, // pci system error, low active
   output logic o_nmi_n, // cpu nmi, low active
   input wire logic i_mst_start, // our pci master access starts
   input wire logic i_mst_done, // our master access completed
   input wire logic i_mst_retry, // our master access retried
   input wire logic i_mst_abort, // master or target abort
   input wire logic i_retry_limit, // retry counter at limit
   input wire logic i_bus_lock_free, // bus allows lock now
   input wire logic i_frame_n, // pci frame, low active
   input wire logic i_lock_n, // pci lock wire, low active
   output logic o_lock_n, // pci lock we drive, low active
   output logic o_lock_oe, // lock output enable
   output logic o_excl_only, // restrict to locked target
   output logic o_mst_redo, // retry locked transfer
   output logic o_tgt_locked, // we are a locked target
   input wire logic i_refresh_req, // dram refresh request
   output logic o_refresh_ok // dram refresh granted
);
   pml_pkg::pml_top_state_type st_reg; // registered state
   pml_pkg::pml_top_state_type st_next; // next state
   pml_if lk_if (); // link to the lock engine
   logic addon; // add-on board mode
   logic [ADDR_W-1:0] ofs_slot [2]; // mailbox offsets

   assign addon = st_reg.en[`PML_EN_ADDON];
   assign ofs_slot[0] = ADDR_W'(`PML_OFS_SLOT_ONE);
   assign ofs_slot[1] = ADDR_W'(`PML_OFS_SLOT_TWO);

   // inputs for the lock engine
   assign lk_if.lock_request = st_reg.lock_req;
   assign lk_if.unlock_dis = st_reg.unlock_dis;
   assign lk_if.mst_start = i_mst_start;
   assign lk_if.mst_done = i_mst_done;
   assign lk_if.mst_retry = i_mst_retry;
   assign lk_if.mst_abort = i_mst_abort;
   assign lk_if.retry_limit = i_retry_limit;
   assign lk_if.bus_lock_free = i_bus_lock_free;
   // a cycle retried before setup completes must never lock us as target
   assign lk_if.tgt_start = i_pci_req && st_reg.en[`PML_EN_CFG_DONE];
   assign lk_if.frame_n = i_frame_n;
   assign lk_if.lock_n = i_lock_n;

   pml_lock_ctl u_lock
   (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .lk(lk_if)
   );

   // register file, interrupts and mailboxes
   always_comb
   begin
      st_next = st_reg;
      st_next.cpu_ack = 1'b0;
      st_next.cpu_retry = 1'b0;
      st_next.pci_ack = 1'b0;
      st_next.pci_retry = 1'b0;
      // pulse bits live one clock only
      st_next.en[`PML_EN_SET_INT] = 1'b0;
      st_next.en[`PML_EN_RST_NMI] = 1'b0;
      // refresh is never gated by the lock state
      st_next.refresh_ok = i_refresh_req;
      // pci clear of the interrupt first, so a cpu set wins
      if (i_pci_int_wr)
      begin
         st_next.inta_n = 1'b1;
      end
      // cpu side
      if (i_cpu_req)
      begin
         if (lk_if.tgt_locked)
         begin
            st_next.cpu_retry = 1'b1;
         end
         else
         begin
            st_next.cpu_ack = 1'b1;
            st_next.cpu_rdata = 32'h0000_0000; // unmapped reads zero
            for (int i = 0; i < `PML_SLOT_COUNT; i++)
            begin
               if (i_cpu_addr == ofs_slot[i])
               begin
                  st_next.mb_flag[i] = 1'b0;
                  st_next.cpu_rdata = st_reg.slot[i];
                  if (i_cpu_wr)
                  begin
                     st_next.slot[i] = i_cpu_wdata;
                  end
               end
            end
            if (i_cpu_addr == ADDR_W'(`PML_OFS_LOCK_CTL))
            begin
               st_next.cpu_rdata = {28'h000_0000, st_reg.abort_hit, st_reg.rlim_hit,
                                    st_reg.unlock_dis, st_reg.lock_req};
               if (i_cpu_wr)
               begin
                  st_next.lock_req = i_cpu_wdata[`PML_LK_REQ];
                  st_next.unlock_dis = i_cpu_wdata[`PML_LK_UNLOCK];
                  // a one leaves a flag alone, a zero clears it
                  st_next.rlim_hit = st_reg.rlim_hit & i_cpu_wdata[`PML_LK_RLIM];
                  st_next.abort_hit = st_reg.abort_hit & i_cpu_wdata[`PML_LK_ABORT];
               end
            end
            if (i_cpu_addr == ADDR_W'(`PML_OFS_ENABLES))
            begin
               // pulse bit reads the interrupt line
               st_next.cpu_rdata = {27'h000_0000, st_reg.en[`PML_EN_RST_NMI],
                                    !st_reg.inta_n, st_reg.en[2:0]};
               if (i_cpu_wr)
               begin
                  st_next.en[2:0] = i_cpu_wdata[2:0];
                  // interrupt controls act only in add-on mode
                  if (addon && i_cpu_wdata[`PML_EN_SET_INT])
                  begin
                     st_next.en[`PML_EN_SET_INT] = 1'b1;
                     st_next.inta_n = 1'b0;
                  end
                  if (addon && i_cpu_wdata[`PML_EN_RST_NMI])
                  begin
                     st_next.en[`PML_EN_RST_NMI] = 1'b1;
                     st_next.nmi_n = 1'b1;
                  end
               end
            end
         end
      end
      // pci side; after the cpu so a pci flag set wins
      if (i_pci_req)
      begin
         if (!st_reg.en[`PML_EN_CFG_DONE])
         begin
            st_next.pci_retry = 1'b1;
         end
         else if (lk_if.tgt_locked && i_lock_n)
         begin
            // a master without lock is not the locking one
            st_next.pci_retry = 1'b1;
         end
         else if (i_pci_mem && i_mem_space_on && (|i_pci_slot_hit))
         begin
            st_next.pci_ack = 1'b1;
            for (int i = 0; i < `PML_SLOT_COUNT; i++)
            begin
               if (i_pci_slot_hit[i])
               begin
                  st_next.mb_flag[i] = 1'b1;
                  st_next.pci_rdata = st_reg.slot[i];
                  if (i_pci_wr)
                  begin
                     st_next.slot[i] = i_pci_wdata;
                  end
               end
            end
         end
      end
      // system error wins over the release write
      if (!i_serr_n)
      begin
         st_next.nmi_n = 1'b0;
      end
      // hardware status sets win over software clears
      if (lk_if.rlim_set)
      begin
         st_next.rlim_hit = 1'b1;
      end
      if (lk_if.abort_set)
      begin
         st_next.abort_hit = 1'b1;
      end
   end

   // state register
   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         st_reg <= '{en: `PML_EN_RST, inta_n: 1'b1, nmi_n: 1'b1, default: '0};
      end
      else if (i_clk_en)
      begin
         st_reg <= st_next;
      end
   end

   // outputs, all from flops
   assign o_cpu_rdata = st_reg.cpu_rdata;
   assign o_cpu_ack = st_reg.cpu_ack;
   assign o_cpu_retry = st_reg.cpu_retry;
   assign o_pci_rdata = st_reg.pci_rdata;
   assign o_pci_ack = st_reg.pci_ack;
   assign o_pci_retry = st_reg.pci_retry;
   assign o_mb_flags = st_reg.mb_flag;
   assign o_inta_n = st_reg.inta_n;
   assign o_nmi_n = st_reg.nmi_n;
   assign o_refresh_ok = st_reg.refresh_ok;
   assign o_lock_n = lk_if.lock_n_drv;
   assign o_lock_oe = lk_if.lock_oe;
   assign o_excl_only = lk_if.excl_only;
   assign o_mst_redo = lk_if.redo;
   assign o_tgt_locked = lk_if.tgt_locked;

   // checks; frozen cycles are skipped
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst || !i_clk_en);

   chk_cfg_retry_gate: assert property (
      i_clk_en && i_pci_req && !st_reg.en[`PML_EN_CFG_DONE] |=> o_pci_retry && !o_pci_ack)
      else $error("target cycle not retried before setup complete");
   chk_int_pulse_set: assert property (
      i_clk_en && i_cpu_req && i_cpu_wr && !lk_if.tgt_locked && addon
      && i_cpu_addr == ADDR_W'(`PML_OFS_ENABLES) && i_cpu_wdata[`PML_EN_SET_INT]
      |=> !o_inta_n ##1 !st_reg.en[`PML_EN_SET_INT])
      else $error("pulse write did not raise interrupt or self-clear");
   chk_int_readback: assert property (
      i_clk_en && i_cpu_req && !i_cpu_wr && !lk_if.tgt_locked
      && i_cpu_addr == ADDR_W'(`PML_OFS_ENABLES)
      |=> o_cpu_rdata[`PML_EN_SET_INT] == !$past(o_inta_n) && o_cpu_rdata[31:5] == 27'h0)
      else $error("pulse bit readback wrong");
   chk_int_pci_clear: assert property (
      i_clk_en && i_pci_int_wr && !(i_cpu_req && i_cpu_wr) |=> o_inta_n)
      else $error("pci write did not negate interrupt");
   chk_nmi_on_serr: assert property (
      i_clk_en && !i_serr_n |=> !o_nmi_n)
      else $error("nmi not asserted on system error");
   chk_mb_flag_set: assert property (
      i_clk_en && i_pci_req && st_reg.en[`PML_EN_CFG_DONE] && !lk_if.tgt_locked && i_pci_mem
      && i_mem_space_on && i_pci_slot_hit[0] |=> o_mb_flags[0] && o_pci_ack)
      else $error("pci mailbox access left flag clear");
   chk_mb_flag_clear: assert property (
      i_clk_en && i_cpu_req && !lk_if.tgt_locked && i_cpu_addr == ofs_slot[1] && !i_pci_req
      |=> !o_mb_flags[1])
      else $error("cpu mailbox access did not clear flag");
   chk_lock_cpu_refuse: assert property (
      i_clk_en && i_cpu_req && lk_if.tgt_locked |=> o_cpu_retry && !o_cpu_ack)
      else $error("cpu access taken while target locked");
   chk_abort_sticky: assert property (
      i_clk_en && lk_if.abort_set |=> st_reg.abort_hit)
      else $error("abort status not recorded");
   chk_lock_drive: assert property (
      i_clk_en && st_reg.lock_req && i_mst_start && i_bus_lock_free && !lk_if.tgt_locked
      |=> !o_lock_n && o_lock_oe && o_excl_only)
      else $error("lock not taken on exclusive request");

   cov_target_lock: cover property (lk_if.tgt_locked ##1 !lk_if.tgt_locked);
   cov_master_lock: cover property (o_lock_oe ##[1:20] !o_lock_oe);
   cov_pci_mailbox: cover property (o_pci_ack ##[1:20] o_cpu_ack && !o_mb_flags[0]);
endmodule : pml_top

// ### testbench/pml_far_side.sv
`timescale 1ns/100ps
// far side of our pci master: starts one access per request and answers it
module pml_far_side
#(
   parameter int DELAY = 3 // cycles a slow target takes to answer
)
(
   input wire logic i_clk_sys, // system clock
   input wire logic i_sys_rst, // synchronous reset, high
   input wire logic i_go, // bench asks for one access
   input wire logic [1:0] i_mode, // 0 done, 1 retry, 2 abort, 3 limit
   output logic o_start, // access starts
   output logic o_done, // access completed
   output logic o_retry, // target asked for retry
   output logic o_abort, // master or target abort
   output logic o_limit // retry counter reached its limit
);
   logic busy_reg; // one access in flight
   logic [3:0] cnt_reg; // answer delay
   logic [1:0] mode_reg; // latched answer kind
   // every pulse lasts one cycle; one answer per access, never two at once
   always_ff @(posedge i_clk_sys)
   begin
      {o_start, o_done, o_retry, o_abort, o_limit} <= 5'h00;
      if (i_sys_rst)
      begin
         busy_reg <= 1'b0;
         cnt_reg <= 4'h0;
         mode_reg <= 2'h0;
      end
      else if (!busy_reg && i_go)
      begin
         o_start <= 1'b1;
         busy_reg <= 1'b1;
         cnt_reg <= 4'(DELAY);
         mode_reg <= i_mode;
      end
      else if (busy_reg && cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
      else if (busy_reg)
      begin
         busy_reg <= 1'b0;
         o_done <= (mode_reg == 2'h0);
         o_retry <= (mode_reg == 2'h1);
         o_abort <= (mode_reg == 2'h2);
         o_limit <= (mode_reg == 2'h3);
      end
   end
endmodule : pml_far_side

// ### testbench/tb_pci_mailbox_lock_control.sv
`timescale 1ns/100ps
module tb_pci_mailbox_lock_control;
   logic clk, rst, cen, creq, cwr, preq, pmem, pspace, pwr, pint, serr_n, bfree;
   logic frame_n, lock_n, rreq, go;
   logic [7:0] caddr;
   logic [31:0] cwd, pwd, rd, d;
   logic [1:0] hit, res, mode;
   logic [31:0] o_cpu_rdata, o_pci_rdata;
   logic o_cpu_ack, o_cpu_retry, o_pci_ack, o_pci_retry, o_inta_n, o_nmi_n, o_lock_n, o_lock_oe;
   logic o_excl_only, o_mst_redo, o_tgt_locked, o_refresh_ok, rt, redo_seen;
   logic [1:0] o_mb_flags;
   logic st, dn, rty, ab, lim;
   int num_errors = 0, checks = 0, cyc = 0, s;

   pml_top uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_cpu_req(creq),
      .i_cpu_wr(cwr), .i_cpu_addr(caddr), .i_cpu_wdata(cwd), .o_cpu_rdata(o_cpu_rdata),
      .o_cpu_ack(o_cpu_ack), .o_cpu_retry(o_cpu_retry), .i_pci_req(preq), .i_pci_mem(pmem),
      .i_mem_space_on(pspace), .i_pci_slot_hit(hit), .i_pci_wr(pwr), .i_pci_wdata(pwd),
      .i_pci_int_wr(pint), .o_pci_rdata(o_pci_rdata), .o_pci_ack(o_pci_ack),
      .o_pci_retry(o_pci_retry), .o_mb_flags(o_mb_flags), .o_inta_n(o_inta_n),
      .i_serr_n(serr_n), .o_nmi_n(o_nmi_n), .i_mst_start(st), .i_mst_done(dn),
      .i_mst_retry(rty), .i_mst_abort(ab), .i_retry_limit(lim), .i_bus_lock_free(bfree),
      .i_frame_n(frame_n), .i_lock_n(lock_n), .o_lock_n(o_lock_n), .o_lock_oe(o_lock_oe),
      .o_excl_only(o_excl_only), .o_mst_redo(o_mst_redo), .o_tgt_locked(o_tgt_locked),
      .i_refresh_req(rreq), .o_refresh_ok(o_refresh_ok));
   pml_far_side #(.DELAY(3)) far_end (.i_clk_sys(clk), .i_sys_rst(rst), .i_go(go),
      .i_mode(mode), .o_start(st), .o_done(dn), .o_retry(rty), .o_abort(ab), .o_limit(lim));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard; also latches the one-cycle redo pulse for later checks
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (o_mst_redo === 1'b1)
         redo_seen <= 1'b1;
      if (cyc == 20000)
      begin
         num_errors = num_errors + 1;
         finish_test();
      end
   end

   task finish_test();
      if (num_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one cpu word access; answer is registered on the same edge that takes the request
   task cpu(input logic w, input logic [7:0] a, input logic [31:0] dw);
      @(posedge clk);
      creq <= 1'b1;
      cwr <= w;
      caddr <= a;
      cwd <= dw;
      @(posedge clk);
      creq <= 1'b0;
      #1;
      rd = o_cpu_rdata;
      rt = o_cpu_retry;
      if (rt !== 1'b1)
         chk({31'h0, o_cpu_ack}, 32'h1);
   endtask : cpu

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      cpu(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk

   // one pci target cycle; res is {retry, ack}
   task pci(input logic [1:0] h, input logic w, input logic [31:0] dw);
      @(posedge clk);
      preq <= 1'b1;
      hit <= h;
      pwr <= w;
      pwd <= dw;
      @(posedge clk);
      preq <= 1'b0;
      #1;
      res = {o_pci_retry, o_pci_ack};
      rd = o_pci_rdata;
   endtask : pci

   // one access of our master, answered by the far side after its delay
   task far(input logic [1:0] m);
      @(posedge clk);
      go <= 1'b1;
      mode <= m;
      @(posedge clk);
      go <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask : far

   // slot offset from slot index
   function logic [7:0] slot_ofs(input int i);
      return (i == 1) ? 8'h34 : 8'h30;
   endfunction : slot_ofs

   initial
   begin
      {rst, cen, bfree, serr_n, frame_n, lock_n} = 6'h3f;
      {creq, cwr, preq, pmem, pspace, pwr, pint, rreq, go, redo_seen} = 10'h000;
      {caddr, cwd, pwd, hit, mode} = 76'h0;
      s = $urandom(32'hdd0a4cb5);
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'h74, 32'h0);
      rd_chk(8'h60, 32'h0);
      chk({29'h0, o_inta_n, o_nmi_n, o_lock_n}, 32'h7);
      // slot hits come decoded, as if the host set the base before space on
      {pmem, pspace} <= 2'b11;
      pci(2'b01, 1'b1, 32'h1);
      chk(res, 2'b10);
      cpu(1'b1, 8'h74, 32'hffffffe7);
      rd_chk(8'h74, 32'h7);
      // mailboxes, random slot and data, both directions
      repeat (6)
      begin
         s = $urandom % 2;
         d = $urandom;
         pci(2'(1 << s), 1'b1, d);
         chk(res, 2'b01);
         chk(o_mb_flags[s], 1'b1);
         rd_chk(slot_ofs(s), d);
         chk(o_mb_flags[s], 1'b0);
         d = $urandom;
         cpu(1'b1, slot_ofs(s), d);
         pci(2'(1 << s), 1'b0, 32'h0);
         chk(rd, d);
         chk(o_mb_flags[s], 1'b1);
      end
      // not a memory cycle, or memory space off: no answer
      for (s = 0; s < 3; s++)
      begin
         {pmem, pspace} <= 2'(s);
         pci(2'b10, 1'b1, 32'h5);
         chk(res, 2'b00);
      end
      {pmem, pspace} <= 2'b11;
      // leave add-on mode first; the pulse bit obeys the mode already stored
      cpu(1'b1, 8'h74, 32'h5);
      cpu(1'b1, 8'h74, 32'hd);
      chk(o_inta_n, 1'b1);
      cpu(1'b1, 8'h74, 32'h7);
      cpu(1'b1, 8'h74, 32'hf);
      chk(o_inta_n, 1'b0);
      rd_chk(8'h74, 32'hf);
      @(posedge clk);
      pint <= 1'b1;
      @(posedge clk);
      pint <= 1'b0;
      @(posedge clk);
      #1;
      chk(o_inta_n, 1'b1);
      rd_chk(8'h74, 32'h7);
      serr_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(o_nmi_n, 1'b0);
      serr_n <= 1'b1;
      cpu(1'b1, 8'h74, 32'h17);
      @(posedge clk);
      #1;
      chk(o_nmi_n, 1'b1);
      rd_chk(8'h74, 32'h7);
      // our master locks a target
      bfree <= 1'b0;
      cpu(1'b1, 8'h60, 32'h1);
      far(2'h1);
      chk(o_lock_n, 1'b1);
      bfree <= 1'b1;
      far(2'h0);
      chk({o_lock_n, o_lock_oe, o_excl_only}, 3'b011);
      far(2'h1);
      chk(redo_seen, 1'b1);
      far(2'h2);
      rd_chk(8'h60, 32'h9);
      far(2'h3);
      rd_chk(8'h60, 32'hd);
      cpu(1'b1, 8'h60, 32'hc);
      chk({o_lock_n, o_lock_oe, o_excl_only}, 3'b011);
      far(2'h0);
      chk({o_lock_n, o_lock_oe, o_excl_only}, 3'b100);
      rd_chk(8'h60, 32'hc);
      cpu(1'b1, 8'h60, 32'h0);
      rd_chk(8'h60, 32'h0);
      // we become a locked target
      cpu(1'b1, 8'h60, 32'h2);
      {frame_n, lock_n} <= 2'b00;
      pci(2'b01, 1'b0, 32'h0);
      chk(o_tgt_locked, 1'b0);
      {frame_n, lock_n} <= 2'b11;
      cpu(1'b1, 8'h60, 32'h0);
      {frame_n, lock_n} <= 2'b00;
      pci(2'b01, 1'b0, 32'h0);
      chk(o_tgt_locked, 1'b1);
      cpu(1'b0, 8'h30, 32'h0);
      chk(rt, 1'b1);
      lock_n <= 1'b1;
      pci(2'b01, 1'b0, 32'h0);
      chk(res, 2'b10);
      rreq <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(o_refresh_ok, 1'b1);
      frame_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(o_tgt_locked, 1'b0);
      // clock enable low: a system error must not reach the nmi flop
      cen <= 1'b0;
      serr_n <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(o_nmi_n, 1'b1);
      cen <= 1'b1;
      serr_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(o_nmi_n, 1'b1);
      finish_test();
   end
endmodule : tb_pci_mailbox_lock_control
